// file: include/csel_regs.svh
// register offsets, field positions and link counts of the card command block
`ifndef CSEL_REGS_SVH
`define CSEL_REGS_SVH
// =====================================
// register offsets
`define CSEL_OFF_CTRL    12'h000
`define CSEL_OFF_STATUS  12'h004
`define CSEL_OFF_WP      12'h008
`define CSEL_OFF_PWLEN   12'h00c
`define CSEL_OFF_ERSEL   12'h010
`define CSEL_OFF_MEMPTR  12'h014
`define CSEL_OFF_MEMDATA 12'h018
// =====================================
// status bits and the control power-cycle bit
`define CSEL_ST_LOCKED   0
`define CSEL_ST_SELECTED 1
`define CSEL_ST_WIDE     2
`define CSEL_ST_LOCKFAIL 3
`define CSEL_ST_ERPARAM  4
`define CSEL_ST_REFUSED  5
`define CSEL_ST_RDACT    6
`define CSEL_ST_WRACT    7
`define CSEL_CTRL_PCYCLE 0
// =====================================
// command indices and the 4-bit width argument
`define CSEL_CMD_IDLE    6'h00
`define CSEL_CMD_WIDTH   6'h06
`define CSEL_CMD_SELECT  6'h07
`define CSEL_CMD_RDSTRM  6'h0b
`define CSEL_CMD_STOP    6'h0c
`define CSEL_CMD_BLKLEN  6'h10
`define CSEL_CMD_WRSTRM  6'h14
`define CSEL_CMD_WPSET   6'h1c
`define CSEL_CMD_WPCLR   6'h1d
`define CSEL_CMD_WPSEND  6'h1e
`define CSEL_CMD_TAGSS   6'h20
`define CSEL_CMD_TAGSE   6'h21
`define CSEL_CMD_TAGGS   6'h23
`define CSEL_CMD_TAGGE   6'h24
`define CSEL_CMD_ERASE   6'h26
`define CSEL_CMD_LOCK    6'h2a
`define CSEL_CMD_APP     6'h37
`define CSEL_WIDTH_4     2'h2
// =====================================
// lock block layout
`define CSEL_LK_ERASE    3
`define CSEL_LK_LOCK     2
`define CSEL_LK_CLR      1
`define CSEL_LK_SET      0
`define CSEL_LK_FORCE    8'h08
`define CSEL_LK_PW_BYTE  8'h02
`define CSEL_BUF_BYTES   8'h22
`define CSEL_PW_BYTES    8'h10
// =====================================
// sizes and counts
`define CSEL_MEM_BYTES   32'h40
`define CSEL_SECT_SHIFT  3
`define CSEL_GRP_SHIFT   5
`define CSEL_NSECT       8
`define CSEL_WP_SHIFT    4
`define CSEL_NWP         32'h4
`define CSEL_FRAME_LAST  6'h2f
`define CSEL_CRC_BITS    32'h10
`define CSEL_WP_FRAME    8'h32
`define CSEL_CRC_POLY    16'h1021
`define CSEL_OE_1B       4'h1
`define CSEL_OE_4B       4'hf
`endif

// file: include/csel_pkg.sv
// types shared by the card command block
package csel_pkg;
`include "csel_regs.svh"
  typedef enum logic [6:0] {
    DS_IDLE      = 7'h01,
    DS_WR_WAIT   = 7'h02,
    DS_WR_STREAM = 7'h04,
    DS_BLK_WAIT  = 7'h08,
    DS_BLK_RX    = 7'h10,
    DS_RD_STREAM = 7'h20,
    DS_WP_TX     = 7'h40
  } csel_dstate_t;
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } csel_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } csel_apb_rsp_t;
  typedef struct packed {
    logic       clk;
    logic       cmd;
    logic [3:0] dat;
  } csel_link_in_t;
  typedef struct packed {
    logic [3:0] dat;
    logic [3:0] oe;
  } csel_link_out_t;
  typedef struct packed {
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic [2:0]   clk_sync;
    logic [1:0]   cmd_sync;
    logic [7:0]   dat_sync;
    logic [3:0]   dat_out;
    logic [3:0]   dat_oe;
    logic         cmd_busy;
    logic [5:0]   cmd_cnt;
    logic [47:0]  cmd_sr;
    logic         app_pending;
    logic         selected;
    logic         wide;
    logic         locked;
    logic         lock_fail;
    logic         erase_param;
    logic         refused;
    logic [7:0]   blk_len;
    csel_dstate_t ds;
    logic [31:0]  addr;
    logic [7:0]   byte_sr;
    logic [2:0]   bit_cnt;
    logic [7:0]   cnt;
    logic [271:0] lk_buf;
    logic [49:0]  wp_sr;
    logic [31:0]  er_start;
    logic         er_group;
    logic         er_tagged;
    logic [7:0]   er_mask;
    logic [3:0]   wp_bits;
    logic [127:0] stored_password;
    logic [7:0]   password_byte_count;
    logic [511:0] mem;
    logic [5:0]   mem_ptr;
  } csel_state_t;
endpackage

// file: verilog/csel_top.sv
// card-side stream, erase, protect and lock command block
`timescale 1ns/1ps
`include "csel_regs.svh"
module csel_top
  import csel_pkg::*;
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // register bus
  input  wire csel_apb_req_t apb_req,
  output csel_apb_rsp_t      apb_rsp,
  // card link pins
  input  wire csel_link_in_t link_in,
  output csel_link_out_t     link_out
);

  // =====================================
  // helpers
  function automatic logic [7:0] byte_at(input logic [511:0] m, input logic [31:0] a);
    if (a < `CSEL_MEM_BYTES) begin
      byte_at = m[8*a[5:0] +: 8];
    end else begin
      byte_at = 8'h00;
    end
  endfunction

  function automatic logic [7:0] buf_byte(input logic [271:0] b, input logic [7:0] k);
    if (k < `CSEL_BUF_BYTES) begin
      buf_byte = b[8*k +: 8];
    end else begin
      buf_byte = 8'h00;
    end
  endfunction

  function automatic logic [15:0] crc16(input logic [31:0] d);
    crc16 = 16'h0000;
    for (int i = 31; i >= 0; i--) begin
      if (crc16[15] ^ d[i]) begin
        crc16 = {crc16[14:0], 1'b0} ^ `CSEL_CRC_POLY;
      end else begin
        crc16 = {crc16[14:0], 1'b0};
      end
    end
  endfunction

  function automatic logic is_data_cmd(input logic [5:0] i);
    is_data_cmd = i inside {`CSEL_CMD_RDSTRM, `CSEL_CMD_WRSTRM, `CSEL_CMD_WPSET,
                            `CSEL_CMD_WPCLR, `CSEL_CMD_WPSEND, `CSEL_CMD_TAGSS,
                            `CSEL_CMD_TAGSE, `CSEL_CMD_TAGGS, `CSEL_CMD_TAGGE,
                            `CSEL_CMD_ERASE};
  endfunction

  function automatic logic pw_match(input logic [127:0] pw, input logic [271:0] b,
                                    input logic [7:0] n);
    pw_match = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (8'(i) < n && buf_byte(b, 8'(i + 2)) != pw[8*i +: 8]) begin
        pw_match = 1'b0;
      end
    end
  endfunction

  function automatic logic [127:0] pw_new(input logic [271:0] b, input logic [7:0] old,
                                          input logic [7:0] n);
    pw_new = '0;
    for (int i = 0; i < 16; i++) begin
      if (8'(i) < n) begin
        pw_new[8*i +: 8] = buf_byte(b, 8'(`CSEL_LK_PW_BYTE + old + 8'(i)));
      end
    end
  endfunction

  function automatic logic [31:0] wp_word(input logic [3:0] wp, input logic [31:0] a);
    logic [31:0] g;
    g = a >> `CSEL_WP_SHIFT;
    wp_word = '0;
    for (int i = 0; i < 32; i++) begin
      if (g + 32'(i) < `CSEL_NWP) begin
        wp_word[i] = wp[2'(g + 32'(i))];
      end
    end
  endfunction

  function automatic logic [7:0] er_sel(input logic [31:0] st, input logic [31:0] en,
                                        input logic grp);
    int sh;
    logic [31:0] u;
    sh = grp ? `CSEL_GRP_SHIFT : `CSEL_SECT_SHIFT;
    er_sel = '0;
    for (int i = 0; i < `CSEL_NSECT; i++) begin
      u = 32'(i << `CSEL_SECT_SHIFT) >> sh;
      er_sel[i] = ((st >> sh) <= u) && (u <= (en >> sh));
    end
  endfunction

  function automatic logic [31:0] status_of(input csel_state_t q);
    status_of = '0;
    status_of[`CSEL_ST_LOCKED]   = q.locked;
    status_of[`CSEL_ST_SELECTED] = q.selected;
    status_of[`CSEL_ST_WIDE]     = q.wide;
    status_of[`CSEL_ST_LOCKFAIL] = q.lock_fail;
    status_of[`CSEL_ST_ERPARAM]  = q.erase_param;
    status_of[`CSEL_ST_REFUSED]  = q.refused;
    status_of[`CSEL_ST_RDACT]    = q.ds == DS_RD_STREAM;
    status_of[`CSEL_ST_WRACT]    = q.ds == DS_WR_STREAM;
  endfunction

  // =====================================
  // state and decode terms
  csel_state_t r;
  csel_state_t s;
  logic        rise;
  logic        fall;
  logic [3:0]  dat_in;
  logic [47:0] frame;
  logic        cmd_done;
  logic [5:0]  idx;
  logic [31:0] arg;
  logic        setup;
  logic        wr_acc;
  logic [2:0]  step;
  logic        byte_end;
  logic [7:0]  nb;
  logic        lk_done;
  logic [7:0]  mode;
  logic [7:0]  plen;
  logic [7:0]  pl;
  logic [7:0]  newlen;
  logic        match;

  assign rise     = r.clk_sync[1] & ~r.clk_sync[2];
  assign fall     = ~r.clk_sync[1] & r.clk_sync[2];
  assign dat_in   = r.dat_sync[7:4];
  assign frame    = {r.cmd_sr[46:0], r.cmd_sync[1]};
  assign cmd_done = rise & r.cmd_busy & (r.cmd_cnt == `CSEL_FRAME_LAST);
  assign idx      = frame[45:40];
  assign arg      = frame[39:8];
  assign setup    = apb_req.psel & ~apb_req.penable;
  assign wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite & r.pready;
  assign step     = r.wide ? 3'h4 : 3'h1;
  assign byte_end = 3'(r.bit_cnt + step) == 3'h0;
  assign nb       = r.wide ? {r.byte_sr[3:0], dat_in} : {r.byte_sr[6:0], dat_in[0]};
  assign lk_done  = rise && r.ds == DS_BLK_RX && r.cnt >= r.blk_len
                    && r.addr == `CSEL_CRC_BITS;
  assign mode     = buf_byte(r.lk_buf, 8'h00);
  assign plen     = buf_byte(r.lk_buf, 8'h01);
  assign pl       = r.password_byte_count;
  assign newlen   = 8'(plen - pl);
  assign match    = pw_match(r.stored_password, r.lk_buf, pl);

  assign apb_rsp  = '{prdata: r.prdata, pready: r.pready, pslverr: r.pslverr};
  assign link_out = '{dat: r.dat_out, oe: r.dat_oe};

  // =====================================
  // next state
  always_comb begin
    s = r;
    s.clk_sync = {r.clk_sync[1:0], link_in.clk};
    s.cmd_sync = {r.cmd_sync[0], link_in.cmd};
    s.dat_sync = {r.dat_sync[3:0], link_in.dat};
    // register bus: data captured in setup, answered in access
    s.pready  = setup;
    s.pslverr = 1'b0;
    if (setup) begin
      if (apb_req.paddr == `CSEL_OFF_CTRL) begin
        s.prdata = '0;
      end else if (apb_req.paddr == `CSEL_OFF_STATUS) begin
        s.prdata = status_of(r);
      end else if (apb_req.paddr == `CSEL_OFF_WP) begin
        s.prdata = {28'h0, r.wp_bits};
      end else if (apb_req.paddr == `CSEL_OFF_PWLEN) begin
        s.prdata = {24'h0, r.password_byte_count};
      end else if (apb_req.paddr == `CSEL_OFF_ERSEL) begin
        s.prdata = {24'h0, r.er_mask};
      end else if (apb_req.paddr == `CSEL_OFF_MEMPTR) begin
        s.prdata = {26'h0, r.mem_ptr};
      end else if (apb_req.paddr == `CSEL_OFF_MEMDATA) begin
        s.prdata = {24'h0, byte_at(r.mem, {26'h0, r.mem_ptr})};
      end else begin
        s.prdata  = '0;
        s.pslverr = 1'b1;
      end
    end
    if (wr_acc) begin
      if (apb_req.paddr == `CSEL_OFF_CTRL) begin
        if (apb_req.pwdata[`CSEL_CTRL_PCYCLE]) begin
          // power cycle: password kept, lock follows stored length
          s.locked   = r.password_byte_count != 8'h00;
          s.wide     = 1'b0;
          s.selected = 1'b0;
          s.ds       = DS_IDLE;
          s.dat_oe   = 4'h0;
        end
      end else if (apb_req.paddr == `CSEL_OFF_STATUS) begin
        if (apb_req.pwdata[`CSEL_ST_LOCKFAIL]) s.lock_fail = 1'b0;
        if (apb_req.pwdata[`CSEL_ST_ERPARAM]) s.erase_param = 1'b0;
        if (apb_req.pwdata[`CSEL_ST_REFUSED]) s.refused = 1'b0;
      end else if (apb_req.paddr == `CSEL_OFF_MEMPTR) begin
        s.mem_ptr = apb_req.pwdata[5:0];
      end else if (apb_req.paddr == `CSEL_OFF_MEMDATA) begin
        s.mem[8*r.mem_ptr +: 8] = apb_req.pwdata[7:0];
      end
    end
    // data line engine
    case (r.ds)
      DS_WR_WAIT: begin
        if (rise && !dat_in[0]) begin
          s.ds      = DS_WR_STREAM;
          s.bit_cnt = 3'h0;
        end
      end
      DS_WR_STREAM: begin
        if (rise) begin
          s.byte_sr = nb;
          s.bit_cnt = 3'(r.bit_cnt + step);
          if (byte_end) begin
            if (r.addr < `CSEL_MEM_BYTES) begin
              s.mem[8*r.addr[5:0] +: 8] = nb;
            end
            s.addr = r.addr + 32'h1;
          end
        end
      end
      DS_BLK_WAIT: begin
        if (rise && !dat_in[0]) begin
          s.ds      = DS_BLK_RX;
          s.bit_cnt = 3'h0;
          s.cnt     = 8'h00;
          s.addr    = '0;
        end
      end
      DS_BLK_RX: begin
        if (rise) begin
          if (r.cnt < r.blk_len) begin
            s.byte_sr = nb;
            s.bit_cnt = 3'(r.bit_cnt + step);
            if (byte_end) begin
              if (r.cnt < `CSEL_BUF_BYTES) s.lk_buf[8*r.cnt +: 8] = nb;
              s.cnt = r.cnt + 8'h1;
            end
          end else begin
            s.addr = r.addr + 32'h1;
          end
        end
      end
      DS_RD_STREAM: begin
        if (fall) begin
          s.dat_oe = r.wide ? `CSEL_OE_4B : `CSEL_OE_1B;
          if (r.cnt == 8'h00) begin
            s.dat_out = 4'h0;
            s.cnt     = 8'h01;
            s.byte_sr = byte_at(r.mem, r.addr);
            s.bit_cnt = 3'h0;
          end else begin
            s.dat_out = r.wide ? r.byte_sr[7:4] : {3'h0, r.byte_sr[7]};
            s.byte_sr = 8'(r.byte_sr << step);
            s.bit_cnt = 3'(r.bit_cnt + step);
            if (byte_end) begin
              s.addr    = r.addr + 32'h1;
              s.byte_sr = byte_at(r.mem, r.addr + 32'h1);
            end
          end
        end
      end
      DS_WP_TX: begin
        if (fall) begin
          if (r.cnt == `CSEL_WP_FRAME) begin
            s.dat_oe = 4'h0;
            s.ds     = DS_IDLE;
          end else begin
            s.dat_out = {3'h0, r.wp_sr[49]};
            s.dat_oe  = `CSEL_OE_1B;
            s.wp_sr   = {r.wp_sr[48:0], 1'b0};
            s.cnt     = r.cnt + 8'h1;
          end
        end
      end
      default: begin
      end
    endcase
    // command line receiver
    if (rise) begin
      if (!r.cmd_busy) begin
        if (!r.cmd_sync[1]) begin
          s.cmd_busy = 1'b1;
          s.cmd_cnt  = 6'h01;
          s.cmd_sr   = '0;
        end
      end else begin
        s.cmd_sr  = frame;
        s.cmd_cnt = 6'(r.cmd_cnt + 6'h1);
        if (cmd_done) s.cmd_busy = 1'b0;
      end
    end
    if (cmd_done) begin
      s.app_pending = 1'b0;
      if (r.locked && is_data_cmd(idx)) begin
        s.refused = 1'b1;
      end else if (idx == `CSEL_CMD_IDLE) begin
        s.selected = 1'b0;
        s.wide     = 1'b0;
        s.ds       = DS_IDLE;
        s.dat_oe   = 4'h0;
      end else if (idx == `CSEL_CMD_SELECT) begin
        s.selected = arg[31:16] != 16'h0;
      end else if (idx == `CSEL_CMD_APP) begin
        s.app_pending = 1'b1;
      end else if (idx == `CSEL_CMD_WIDTH) begin
        if (r.app_pending && r.selected) s.wide = arg[1:0] == `CSEL_WIDTH_4;
      end else if (idx == `CSEL_CMD_STOP) begin
        if (r.ds != DS_BLK_RX && r.ds != DS_BLK_WAIT) begin
          s.ds     = DS_IDLE;
          s.dat_oe = 4'h0;
        end
      end else if (idx == `CSEL_CMD_BLKLEN) begin
        s.blk_len = arg[7:0];
      end else if (!r.selected) begin
        s.refused = 1'b1;
      end else if (idx == `CSEL_CMD_RDSTRM) begin
        s.ds   = DS_RD_STREAM;
        s.addr = arg;
        s.cnt  = 8'h00;
      end else if (idx == `CSEL_CMD_WRSTRM) begin
        s.ds   = DS_WR_WAIT;
        s.addr = arg;
      end else if (idx == `CSEL_CMD_WPSET || idx == `CSEL_CMD_WPCLR) begin
        if ((arg >> `CSEL_WP_SHIFT) < `CSEL_NWP) begin
          s.wp_bits[arg[5:4]] = idx == `CSEL_CMD_WPSET;
        end
      end else if (idx == `CSEL_CMD_WPSEND) begin
        s.ds    = DS_WP_TX;
        s.cnt   = 8'h00;
        s.wp_sr = {1'b0, wp_word(r.wp_bits, arg), crc16(wp_word(r.wp_bits, arg)),
                   1'b1};
      end else if (idx == `CSEL_CMD_TAGSS || idx == `CSEL_CMD_TAGGS) begin
        s.er_start  = arg;
        s.er_group  = idx == `CSEL_CMD_TAGGS;
        s.er_tagged = 1'b1;
        s.er_mask   = '0;
      end else if (idx == `CSEL_CMD_TAGSE || idx == `CSEL_CMD_TAGGE) begin
        s.er_tagged = 1'b0;
        if (!r.er_tagged || r.er_group != (idx == `CSEL_CMD_TAGGE)
            || (!r.er_group && (r.er_start >> `CSEL_GRP_SHIFT)
                != (arg >> `CSEL_GRP_SHIFT))) begin
          s.erase_param = 1'b1;
        end else begin
          s.er_mask = er_sel(r.er_start, arg, r.er_group);
        end
      end else if (idx == `CSEL_CMD_ERASE) begin
        for (int i = 0; i < `CSEL_NSECT; i++) begin
          if (r.er_mask[i]) s.mem[64*i +: 64] = '0;
        end
        s.er_mask = '0;
      end else if (idx == `CSEL_CMD_LOCK) begin
        if (r.ds == DS_IDLE) s.ds = DS_BLK_WAIT;
      end
    end
    // lock block evaluation
    if (lk_done) begin
      s.ds = DS_IDLE;
      if (mode[`CSEL_LK_ERASE]) begin
        if (mode == `CSEL_LK_FORCE && r.locked) begin
          s.mem                 = '0;
          s.stored_password     = '0;
          s.password_byte_count = 8'h00;
          s.locked              = 1'b0;
        end else begin
          s.lock_fail = 1'b1;
        end
      end else if (mode[`CSEL_LK_CLR]) begin
        if (!mode[`CSEL_LK_LOCK] && pl != 8'h00 && plen == pl && match) begin
          s.stored_password     = '0;
          s.password_byte_count = 8'h00;
          s.locked              = 1'b0;
        end else begin
          s.lock_fail = 1'b1;
        end
      end else if (mode[`CSEL_LK_SET]) begin
        if (plen > pl && newlen <= `CSEL_PW_BYTES && match) begin
          s.stored_password     = pw_new(r.lk_buf, pl, newlen);
          s.password_byte_count = newlen;
          if (mode[`CSEL_LK_LOCK]) s.locked = 1'b1;
        end else begin
          s.lock_fail = 1'b1;
        end
      end else if (mode[`CSEL_LK_LOCK]) begin
        if (!r.locked && pl != 8'h00 && plen == pl && match) begin
          s.locked = 1'b1;
        end else begin
          s.lock_fail = 1'b1;
        end
      end else begin
        if (r.locked && plen == pl && match) begin
          s.locked = 1'b0;
        end else begin
          s.lock_fail = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r    <= '0;
      r.ds <= DS_IDLE;
    end else begin
      r <= s;
    end
  end

  // =====================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_stop_in_read;
    r.ds == DS_RD_STREAM && cmd_done && idx == `CSEL_CMD_STOP;
  endsequence

  a_apb_answer: assert property (s_setup |=> r.pready ##1 !r.pready || setup)
    else $error("apb answer not in access phase");
  a_stop_read: assert property (s_stop_in_read |=> r.dat_oe == 4'h0 [*2])
    else $error("read output continues after stop");
  a_stream_store: assert property (r.ds == DS_WR_STREAM && rise && byte_end
      && r.addr < `CSEL_MEM_BYTES |=> byte_at(r.mem, $past(r.addr)) == $past(nb))
    else $error("stream byte not stored");
  a_stream_discard: assert property (r.ds == DS_WR_STREAM && rise && byte_end
      && r.addr >= `CSEL_MEM_BYTES && !wr_acc |=> $stable(r.mem))
    else $error("data past memory end was stored");
  a_idle_narrow: assert property (cmd_done && idx == `CSEL_CMD_IDLE
      |=> !r.wide && !r.selected)
    else $error("idle command left wide bus");
  a_wide_selected: assert property ($rose(r.wide) |-> $past(r.selected))
    else $error("wide bus set while unselected");
  a_locked_refuse: assert property (cmd_done && r.locked && is_data_cmd(idx)
      |=> r.refused && r.ds == $past(r.ds))
    else $error("locked card ran a data command");
  a_power_lock: assert property (wr_acc && apb_req.paddr == `CSEL_OFF_CTRL
      && apb_req.pwdata[`CSEL_CTRL_PCYCLE] && !lk_done
      |=> r.locked == (r.password_byte_count != 8'h00))
    else $error("power cycle lock wrong");
  a_lock_with_clear: assert property (lk_done && mode[`CSEL_LK_LOCK]
      && mode[`CSEL_LK_CLR] && !mode[`CSEL_LK_ERASE]
      |=> r.lock_fail && $stable(r.stored_password))
    else $error("lock with clear accepted");
  a_wp_end_bit: assert property (r.ds == DS_WP_TX && fall && r.cnt == 8'h31
      |=> r.dat_out[0] && r.dat_oe[0])
    else $error("protect frame end bit wrong");
  a_erase_mix: assert property (cmd_done && !r.locked && r.selected && r.er_tagged
      && (idx == `CSEL_CMD_TAGSE && r.er_group || idx == `CSEL_CMD_TAGGE && !r.er_group)
      |=> r.erase_param)
    else $error("mixed erase selection accepted");
endmodule

// file: testbench/csel_host_model.sv
// host controller model driving the card link
`timescale 1ns/1ps
module csel_host_model
  import csel_pkg::*;
(
  // clock
  input  wire logic     pclk,
  // card link pins
  output csel_link_in_t link_in
);
  initial link_in = '{clk: 1'b0, cmd: 1'b1, dat: 4'hf};
  // one link clock period: low half with new bits, then high half
  task automatic tick(input logic c, input logic d);
    @(posedge pclk);
    link_in <= '{clk: 1'b0, cmd: c, dat: {3'h7, d}};
    repeat (4) @(posedge pclk);
    link_in.clk <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  // clock parks low, lines back at pull-up level
  task automatic park();
    @(posedge pclk);
    link_in <= '{clk: 1'b0, cmd: 1'b1, dat: 4'hf};
    repeat (8) @(posedge pclk);
  endtask
  task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg);
    logic [47:0] f;
    f = {2'b01, idx, arg, 8'h01};
    for (int i = 47; i >= 0; i--) tick(f[i], 1'b1);
    park();
  endtask
  // start bit, nb bits msb first, then n idle clocks for check code and end
  task automatic send_dat(input logic [47:0] v, input int nb, input int n);
    tick(1'b1, 1'b0);
    for (int i = nb - 1; i >= 0; i--) tick(1'b1, v[i]);
    repeat (n) tick(1'b1, 1'b1);
    park();
  endtask
  // free clocks while the card drives its data lines
  task automatic clocks(input int n);
    repeat (n) tick(1'b1, 1'b1);
    park();
  endtask
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the card command block
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
  $display("FAIL %0t %h %h", $time, (a), (e)); end end
module tb_top;
  import csel_pkg::*;
  logic           pclk;
  logic           presetn;
  csel_apb_req_t  req;
  csel_apb_rsp_t  rsp;
  csel_link_in_t  lin;
  csel_link_out_t lout;
  logic [31:0]    rd;
  logic           err;
  logic [63:0]    rx;
  int             n_fail;
  int             tests_run;
  int             cyc;
  csel_top uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
                .link_in(lin), .link_out(lout));
  csel_host_model host (.pclk(pclk), .link_in(lin));
  // host side sampling of card data on link clock rises
  always @(posedge lin.clk) begin
    if (lout.oe[0]) rx <= {rx[62:0], lout.dat[0]};
  end
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic results();
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      results();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic mem_is(input logic [5:0] p, input logic [7:0] e);
    apb(1'b1, 12'h014, {26'h0, p});
    rchk(12'h018, {24'h0, e});
  endtask
  initial begin
    req = '0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rchk(12'h004, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    `CHK(err, 1'b1)
    host.send_cmd(6'h07, 32'h00010000);
    host.send_cmd(6'h37, 32'h00010000);
    host.send_cmd(6'h06, 32'h2);
    rchk(12'h004, 32'h6);
    host.send_cmd(6'h00, 32'h0);
    rchk(12'h004, 32'h0);
    host.send_cmd(6'h07, 32'h00010000);
    host.send_cmd(6'h14, 32'h3e);
    host.send_dat(48'h11223344, 32, 2);
    host.send_cmd(6'h0c, 32'h0);
    mem_is(6'h3e, 8'h11);
    mem_is(6'h3f, 8'h22);
    mem_is(6'h00, 8'h00);
    host.send_cmd(6'h0b, 32'h3e);
    host.send_cmd(6'h0c, 32'h0);
    `CHK(rx[47:0], 48'h0891_0000_0000)
    `CHK(lout.oe, 4'h0)
    host.send_cmd(6'h1c, 32'h1f);
    rchk(12'h008, 32'h2);
    host.send_cmd(6'h1d, 32'h13);
    rchk(12'h008, 32'h0);
    host.send_cmd(6'h1c, 32'h2f);
    rchk(12'h008, 32'h4);
    host.send_cmd(6'h1e, 32'h0f);
    host.clocks(52);
    `CHK(rx[49:0], 50'h88109)
    host.send_cmd(6'h20, 32'h08);
    host.send_cmd(6'h21, 32'h10);
    rchk(12'h010, 32'h6);
    host.send_cmd(6'h20, 32'h08);
    host.send_cmd(6'h24, 32'h20);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[4], 1'b1)
    host.send_cmd(6'h23, 32'h20);
    host.send_cmd(6'h24, 32'h3f);
    rchk(12'h010, 32'hf0);
    host.send_cmd(6'h26, 32'h0);
    mem_is(6'h3f, 8'h00);
    apb(1'b1, 12'h004, 32'h38);
    host.send_cmd(6'h10, 32'h4);
    host.send_cmd(6'h2a, 32'h0);
    host.send_dat(48'h0502a55a, 32, 18);
    rchk(12'h004, 32'h3);
    rchk(12'h00c, 32'h2);
    host.send_cmd(6'h14, 32'h0);
    rchk(12'h004, 32'h23);
    host.send_cmd(6'h2a, 32'h0);
    host.send_dat(48'h0002a55b, 32, 18);
    rchk(12'h004, 32'h2b);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[1:0], 2'b01)
    rchk(12'h00c, 32'h2);
    apb(1'b1, 12'h004, 32'h38);
    host.send_cmd(6'h07, 32'h00010000);
    host.send_cmd(6'h2a, 32'h0);
    host.send_dat(48'h0602a55a, 32, 18);
    rchk(12'h004, 32'hb);
    apb(1'b1, 12'h004, 32'h38);
    host.send_cmd(6'h2a, 32'h0);
    host.send_dat(48'h0002a55a, 32, 18);
    rchk(12'h004, 32'h2);
    host.send_cmd(6'h10, 32'h5);
    host.send_cmd(6'h2a, 32'h0);
    host.send_dat(48'h0103a55a3c, 40, 18);
    rchk(12'h00c, 32'h1);
    apb(1'b1, 12'h018, 32'h5c);
    apb(1'b1, 12'h000, 32'h1);
    host.send_cmd(6'h07, 32'h00010000);
    host.send_cmd(6'h10, 32'h1);
    host.send_cmd(6'h2a, 32'h0);
    host.send_dat(48'h08000000, 32, 0);
    rchk(12'h004, 32'h2);
    rchk(12'h00c, 32'h0);
    mem_is(6'h3f, 8'h00);
    results();
  end
endmodule
